// file: xbcs3_pkg.sv
// constants, register map and types for the third expansion-bus chip select
// Functional notes
// - high-byte register holds base address bits 15:8, used only in mode 1.
// - low-byte register holds base address bits 7:2, used only in mode 1.
// - low-byte bit 1 write-protects both bytes; only power-on or hard reset clears.
// - protect set makes both address bytes read-only; clear makes them writable.
// - low-byte bit 0 zero enables the chip select, one disables it.
// - selection bit 0 picks mode 1 or 2; no pin is reconfigured.
// - selection bits 3:2 pick strobe width 180, 300, 420 or 540 ns.
// - host cycles driving a strobe are stretched with wait states to the width.
// - selection bit 7 locks that register; only power-on or hard reset clears.
// - a base outside the permitted range makes accesses to it ignored.
package xbcs3_pkg;

    // register indexes; byte address on the bus is four times the index
    localparam logic [7:0] XBCS3_IDX_BASE_HIGH = 8'h66;
    localparam logic [7:0] XBCS3_IDX_BASE_LOW  = 8'h67;
    localparam logic [7:0] XBCS3_IDX_SELECT    = 8'hf0;

    localparam logic [7:0] XBCS3_RST_BASE_HIGH = 8'h00;
    localparam logic [7:0] XBCS3_RST_BASE_LOW  = 8'h00;
    localparam logic [7:0] XBCS3_RST_SELECT    = 8'h00;

    // low-byte fields
    localparam int XBCS3_LOW_DIS_BIT = 0;
    localparam int XBCS3_LOW_WP_BIT  = 1;
    localparam int XBCS3_LOW_ADR_LSB = 2;

    // selection fields
    localparam int XBCS3_SEL_MODE_BIT = 0;
    localparam int XBCS3_SEL_PW_LSB   = 2;
    localparam int XBCS3_SEL_PW_MSB   = 3;
    localparam int XBCS3_SEL_LOCK_BIT = 7;
    localparam logic [7:0] XBCS3_SEL_WMASK = 8'h0d;

    // permitted base I/O range
    localparam logic [15:0] XBCS3_IO_MIN = 16'h0100;
    localparam logic [15:0] XBCS3_IO_MAX = 16'h0ffc;

    // strobe widths
    localparam int XBCS3_CLK_PERIOD_PS = 5000;
    localparam int XBCS3_PW0_NS        = 180;
    localparam int XBCS3_PW1_NS        = 300;
    localparam int XBCS3_PW2_NS        = 420;
    localparam int XBCS3_PW3_NS        = 540;
    localparam int XBCS3_PW0_CYC = (XBCS3_PW0_NS * 1000 + XBCS3_CLK_PERIOD_PS - 1)
                                   / XBCS3_CLK_PERIOD_PS;
    localparam int XBCS3_PW1_CYC = (XBCS3_PW1_NS * 1000 + XBCS3_CLK_PERIOD_PS - 1)
                                   / XBCS3_CLK_PERIOD_PS;
    localparam int XBCS3_PW2_CYC = (XBCS3_PW2_NS * 1000 + XBCS3_CLK_PERIOD_PS - 1)
                                   / XBCS3_CLK_PERIOD_PS;
    localparam int XBCS3_PW3_CYC = (XBCS3_PW3_NS * 1000 + XBCS3_CLK_PERIOD_PS - 1)
                                   / XBCS3_CLK_PERIOD_PS;
    localparam int XBCS3_CNT_W   = 7;

    typedef enum logic [1:0] {
        XBCS3_IDLE   = 2'b00,
        XBCS3_STROBE = 2'b01,
        XBCS3_DONE   = 2'b10
    } xbcs3_state_e;

endpackage

// file: xbcs3_strobe_timer.sv
// down counter that times one expansion-bus strobe
`timescale 1ns/1ps
module xbcs3_strobe_timer #(
    parameter int CNT_W = 7
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_cycles,
    output logic                  expired
);
    logic [CNT_W-1:0] count_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count_ff <= '0;
        end else if (load) begin
            count_ff <= load_cycles;
        end else if (count_ff != '0) begin
            count_ff <= count_ff - CNT_W'(1);
        end
    end

    // true in the cycle the strobe has lasted its full length
    assign expired = (count_ff == CNT_W'(1));
endmodule

// file: xbcs3_addr_match.sv
// base address compare and permitted range check for the third select
`timescale 1ns/1ps
module xbcs3_addr_match (
    input  wire logic [15:0] host_addr,
    input  wire logic [7:0]  base_high,
    input  wire logic [7:0]  base_low,
    output logic             hit
);
    import xbcs3_pkg::*;

    logic [15:0] base;
    logic        in_range;

    assign base     = {base_high, base_low[7:XBCS3_LOW_ADR_LSB], 2'b00};
    // out-of-range bases never claim a cycle
    assign in_range = (base >= XBCS3_IO_MIN) && (base <= XBCS3_IO_MAX);
    assign hit      = in_range && (host_addr[15:2] == base[15:2]);
endmodule

// file: xbcs3_top.sv
// registers, wishbone slave and strobe sequencer for the third expansion select
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module xbcs3_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // hard reset and soft reset requests from the power logic
    input  wire logic        hard_rst,
    input  wire logic        soft_rst,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // decoded host I/O cycle
    input  wire logic        io_valid,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    output logic             host_wait,
    output logic             io_done,
    // expansion bus side
    output logic             expansion_select_three_n,
    output logic             xbus_rd_n,
    output logic             xbus_wr_n,
    output logic             xbus_mode2
);
    import xbcs3_pkg::*;

    function automatic logic [XBCS3_CNT_W-1:0] strobe_cycles(input logic [1:0] pw);
        case (pw)
            2'b00:   strobe_cycles = XBCS3_CNT_W'(XBCS3_PW0_CYC);
            2'b01:   strobe_cycles = XBCS3_CNT_W'(XBCS3_PW1_CYC);
            2'b10:   strobe_cycles = XBCS3_CNT_W'(XBCS3_PW2_CYC);
            default: strobe_cycles = XBCS3_CNT_W'(XBCS3_PW3_CYC);
        endcase
    endfunction

    function automatic logic idx_is(input logic [9:0] adr, input logic [7:0] idx);
        idx_is = (adr[9:2] == idx);
    endfunction

    logic [7:0]   base_high_ff;
    logic [7:1]   base_low_ff;
    logic         wp_ff;
    logic [7:0]   select_ff;
    logic         ack_ff;
    logic [31:0]  rdata_ff;
    xbcs3_state_e state_ff;
    xbcs3_state_e nxt_state;
    logic         cs_n_ff;
    logic         rd_n_ff;
    logic         wr_n_ff;
    logic         wait_ff;
    logic         done_ff;
    logic         write_cyc_ff;

    logic         wb_req;
    logic         wb_wr;
    logic         wr_high;
    logic         wr_low;
    logic         wr_sel;
    logic [7:0]   base_low;
    logic         mode2;
    logic         cs_disabled;
    logic         addr_hit;
    logic         claim;
    logic         timer_load;
    logic         timer_expired;
    logic [7:0]   rd_byte;
    logic         strobe_start;
    logic         strobe_end;
    logic         nxt_cs_n;
    logic         nxt_rd_n;
    logic         nxt_wr_n;

    // bus decode
    assign wb_req  = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
    // protected address bytes drop writes
    assign wr_high = wb_wr && idx_is(wb_adr_i, XBCS3_IDX_BASE_HIGH) && !wp_ff;
    assign wr_low  = wb_wr && idx_is(wb_adr_i, XBCS3_IDX_BASE_LOW) && !wp_ff;
    // locked selection register drops writes
    assign wr_sel  = wb_wr && idx_is(wb_adr_i, XBCS3_IDX_SELECT)
                     && !select_ff[XBCS3_SEL_LOCK_BIT];

    assign base_low    = {base_low_ff[7:2], wp_ff, base_low_ff[1]};
    assign mode2       = select_ff[XBCS3_SEL_MODE_BIT];
    assign cs_disabled = base_low_ff[1];

    // address bytes
    always_ff @(posedge clk_sys) begin
        if (!rst_b || hard_rst || soft_rst) begin
            base_high_ff <= XBCS3_RST_BASE_HIGH;
        end else if (wr_high) begin
            base_high_ff <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || hard_rst || soft_rst) begin
            base_low_ff <= {XBCS3_RST_BASE_LOW[7:2], XBCS3_RST_BASE_LOW[0]};
        end else if (wr_low) begin
            base_low_ff <= {wb_dat_i[7:XBCS3_LOW_ADR_LSB],
                            wb_dat_i[XBCS3_LOW_DIS_BIT]};
        end
    end

    // write protect: set by software, cleared only by power-on or hard reset
    always_ff @(posedge clk_sys) begin
        if (!rst_b || hard_rst) begin
            wp_ff <= XBCS3_RST_BASE_LOW[XBCS3_LOW_WP_BIT];
        end else if (wr_low && wb_dat_i[XBCS3_LOW_WP_BIT]) begin
            wp_ff <= 1'b1;
        end
    end

    // selection register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            select_ff <= XBCS3_RST_SELECT;
        end else begin
            if (wr_sel) begin
                // reserved bits stay zero, lock only sets
                select_ff[6:0] <= wb_dat_i[6:0] & XBCS3_SEL_WMASK[6:0];
            end
            if (hard_rst) begin
                select_ff[XBCS3_SEL_LOCK_BIT] <= XBCS3_RST_SELECT[XBCS3_SEL_LOCK_BIT];
            end else if (wr_sel && wb_dat_i[XBCS3_SEL_LOCK_BIT]) begin
                select_ff[XBCS3_SEL_LOCK_BIT] <= 1'b1;
            end
        end
    end

    // bus answer: one wait cycle, unmapped words read zero
    always_comb begin
        rd_byte = 8'h00;
        if (idx_is(wb_adr_i, XBCS3_IDX_BASE_HIGH)) begin
            rd_byte = base_high_ff;
        end else if (idx_is(wb_adr_i, XBCS3_IDX_BASE_LOW)) begin
            rd_byte = base_low;
        end else if (idx_is(wb_adr_i, XBCS3_IDX_SELECT)) begin
            rd_byte = select_ff & (XBCS3_SEL_WMASK | 8'h80);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_req;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            rdata_ff <= {24'h00_0000, rd_byte};
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // host cycle decode
    xbcs3_addr_match i_xbcs3_addr_match (
        .host_addr (io_addr),
        .base_high (base_high_ff),
        .base_low  (base_low),
        .hit       (addr_hit)
    );

    // only mode 1 with the select enabled claims cycles
    assign claim = io_valid && addr_hit && !mode2 && !cs_disabled;

    assign timer_load = (state_ff == XBCS3_IDLE) && claim;

    xbcs3_strobe_timer #(
        .CNT_W (XBCS3_CNT_W)
    ) i_xbcs3_strobe_timer (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .load        (timer_load),
        .load_cycles (strobe_cycles(select_ff[XBCS3_SEL_PW_MSB:XBCS3_SEL_PW_LSB])),
        .expired     (timer_expired)
    );

    // strobe sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            XBCS3_IDLE: begin
                if (claim) begin
                    nxt_state = XBCS3_STROBE;
                end
            end
            XBCS3_STROBE: begin
                if (timer_expired) begin
                    nxt_state = XBCS3_DONE;
                end
            end
            XBCS3_DONE: begin
                if (!io_valid) begin
                    nxt_state = XBCS3_IDLE;
                end
            end
            default: begin
                nxt_state = XBCS3_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_ff <= XBCS3_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign strobe_start = timer_load;
    assign strobe_end   = (state_ff == XBCS3_STROBE) && timer_expired;

    // direction latched at claim, so io_write may move under a running strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            write_cyc_ff <= 1'b0;
        end else if (strobe_start) begin
            write_cyc_ff <= io_write;
        end
    end

    // chip select and the one strobe picked by io_write (rd or wr) stay low for the whole timed strobe
    always_comb begin
        nxt_cs_n = cs_n_ff;
        nxt_rd_n = rd_n_ff;
        nxt_wr_n = wr_n_ff;
        if (strobe_start) begin
            nxt_cs_n = 1'b0;
            nxt_rd_n = io_write;
            nxt_wr_n = !io_write;
        end else if (strobe_end) begin
            nxt_cs_n = 1'b1;
            nxt_rd_n = 1'b1;
            nxt_wr_n = 1'b1;
        end else if (state_ff == XBCS3_STROBE) begin
            nxt_rd_n = write_cyc_ff;
            nxt_wr_n = !write_cyc_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cs_n_ff <= 1'b1;
        end else begin
            cs_n_ff <= nxt_cs_n;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_n_ff <= 1'b1;
        end else begin
            rd_n_ff <= nxt_rd_n;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_n_ff <= 1'b1;
        end else begin
            wr_n_ff <= nxt_wr_n;
        end
    end

    // host held in sync wait states until the strobe width is met
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wait_ff <= 1'b0;
        end else if (timer_load) begin
            wait_ff <= 1'b1;
        end else if (state_ff == XBCS3_STROBE && timer_expired) begin
            wait_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == XBCS3_STROBE) && timer_expired;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            xbus_mode2 <= 1'b0;
        end else begin
            xbus_mode2 <= mode2;
        end
    end

    assign expansion_select_three_n = cs_n_ff;
    assign xbus_rd_n                = rd_n_ff;
    assign xbus_wr_n                = wr_n_ff;
    assign host_wait                = wait_ff;
    assign io_done                  = done_ff;

endmodule

// file: xbcs3_chk.sv
// assertion checker for the third expansion select block
`timescale 1ns/1ps
module xbcs3_chk (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        io_valid,
    input wire logic        io_write,
    input wire logic        host_wait,
    input wire logic        io_done,
    input wire logic        expansion_select_three_n,
    input wire logic        xbus_rd_n,
    input wire logic        xbus_wr_n,
    input wire logic        xbus_mode2
);
    localparam int MIN_N = 36;
    localparam int MAX_N = 108;
    logic [6:0] low_cnt_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // counts the cycles the select has been low
    always_ff @(posedge clk_sys) begin
        if (!rst_b || expansion_select_three_n) begin
            low_cnt_ff <= 7'h00;
        end else begin
            low_cnt_ff <= low_cnt_ff + 7'h01;
        end
    end
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    read_idle_a: assert property (wb_dat_o[31:8] == 24'h00_0000
        && (wb_ack_o || wb_dat_o == 32'h0000_0000)) else $error("read data outside ack");
    sel_cause_a: assert property ($fell(expansion_select_three_n) |->
        $past(io_valid) && !xbus_mode2) else $error("select without io cycle in mode one");
    strobe_pair_a: assert property (!expansion_select_three_n |->
        host_wait && (xbus_rd_n != xbus_wr_n)) else $error("strobe or wait wrong");
    width_min_a: assert property ($rose(expansion_select_three_n) |->
        low_cnt_ff >= MIN_N && low_cnt_ff <= MAX_N && io_done) else $error("width off");
    done_end_a: assert property (io_done |-> $rose(expansion_select_three_n) ##1 !io_done)
        else $error("done not at strobe end");
    wr_dir_a: assert property ($fell(xbus_wr_n) |-> $past(io_write))
        else $error("write strobe on read");
    strobe_hold_a: assert property ($fell(expansion_select_three_n) |=>
        (!expansion_select_three_n && host_wait) [*8]) else $error("strobe too short");
    cover property (wb_ack_o);
    cover property ($fell(xbus_wr_n));
    cover property ($fell(xbus_rd_n));
endmodule

bind xbcs3_top xbcs3_chk i_xbcs3_chk (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .io_valid, .io_write, .host_wait, .io_done, .expansion_select_three_n,
    .xbus_rd_n, .xbus_wr_n, .xbus_mode2);

// file: xbcs3_periph.sv
// expansion-bus peripheral model that times each select pulse
`timescale 1ns/1ps
module xbcs3_periph (
    input wire logic clk_sys,
    input wire logic sel_n,
    input wire logic rd_n,
    input wire logic wr_n,
    output int       n_strobes,
    output int       last_width,
    output logic     last_wr
);
    int   cnt      = 0;
    int   n_ff     = 0;
    int   width_ff = 0;
    logic wr_ff    = 1'b0;
    assign n_strobes  = n_ff;
    assign last_width = width_ff;
    assign last_wr    = wr_ff;
    always @(posedge clk_sys) begin
        if (!sel_n) begin
            cnt = cnt + 1;
            wr_ff <= !wr_n && rd_n;
        end else if (cnt != 0) begin
            width_ff <= cnt;
            n_ff <= n_ff + 1;
            cnt = 0;
        end
    end
endmodule

// file: tb_xbcs3_top.sv
// self-checking bench for the third expansion select block
`timescale 1ns/1ps
module tb_xbcs3_top;
    import xbcs3_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        hard_rst = 1'b0;
    logic        soft_rst = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        io_valid = 1'b0;
    logic        io_write = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic        host_wait, io_done, expansion_select_three_n, xbus_rd_n, xbus_wr_n, xbus_mode2;
    logic        last_wr;
    int          n_strobes, last_width;
    int          n_errors = 0;
    int          checked = 0;
    int          w_ns[4] = '{180, 300, 420, 540};

    always #2.5 clk_sys = ~clk_sys;

    xbcs3_top i_xbcs3_top (.clk_sys, .rst_b, .hard_rst, .soft_rst, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .io_valid,
        .io_write, .io_addr, .host_wait, .io_done, .expansion_select_three_n, .xbus_rd_n,
        .xbus_wr_n, .xbus_mode2);
    xbcs3_periph i_xbcs3_periph (.clk_sys, .sel_n(expansion_select_three_n),
        .rd_n(xbus_rd_n), .wr_n(xbus_wr_n), .n_strobes, .last_width, .last_wr);

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rdat);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h00_0000, wd};
        @(posedge clk_sys iff wb_ack_o);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, idx, d, r);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] r;
        wb(1'b0, idx, 8'h00, r);
        check(r, {24'h00_0000, exp}, what);
    endtask

    // one host io cycle; n is the expected strobe length, 0 for none
    task automatic io(input logic [15:0] a, input logic w, input int n);
        int s;
        int nw;
        logic done;
        s = n_strobes;
        nw = 0;
        done = 1'b0;
        @(posedge clk_sys);
        io_valid <= 1'b1;
        io_write <= w;
        io_addr  <= a;
        for (int i = 0; i < 150 && !done; i++) begin
            @(posedge clk_sys);
            done = io_done;
            nw = nw + ((host_wait === 1'b1) ? 1 : 0);
        end
        io_valid <= 1'b0;
        @(posedge clk_sys);
        check(32'(n_strobes - s), 32'(n != 0), "strobe count");
        check(done, n != 0, "io done");
        check(nw, n, "wait states");
        if (n != 0) begin
            check(last_width, n, "strobe width");
            check(last_wr, w, "strobe direction");
        end
    endtask

    task automatic pulse(input bit hard);
        @(posedge clk_sys);
        hard_rst <= hard;
        soft_rst <= !hard;
        @(posedge clk_sys);
        hard_rst <= 1'b0;
        soft_rst <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(XBCS3_IDX_BASE_HIGH, 8'h00, "high reset");
        rd(XBCS3_IDX_BASE_LOW, 8'h00, "low reset");
        rd(XBCS3_IDX_SELECT, 8'h00, "select reset");
        rd(8'h10, 8'h00, "unmapped");
        wr(XBCS3_IDX_BASE_HIGH, 8'h03);
        wr(XBCS3_IDX_BASE_LOW, 8'h00);
        rd(XBCS3_IDX_BASE_HIGH, 8'h03, "high");
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            wr(XBCS3_IDX_SELECT, 8'(p << 2));
            rd(XBCS3_IDX_SELECT, 8'(p << 2), "width field");
            io(16'h0301, p[0], (w_ns[p] + 4) / 5);
        end
        wr(XBCS3_IDX_SELECT, 8'h00);
        io(16'h0304, 1'b0, 0);
        wr(XBCS3_IDX_BASE_LOW, 8'h01);
        io(16'h0300, 1'b0, 0);
        wr(XBCS3_IDX_BASE_LOW, 8'h00);
        wr(XBCS3_IDX_SELECT, 8'h72);
        rd(XBCS3_IDX_SELECT, 8'h00, "reserved");
        wr(XBCS3_IDX_SELECT, 8'h01);
        io(16'h0300, 1'b0, 0);
        check(xbus_mode2, 1'b1, "mode two");
        wr(XBCS3_IDX_SELECT, 8'h00);
        wr(XBCS3_IDX_BASE_HIGH, 8'h00);
        wr(XBCS3_IDX_BASE_LOW, 8'h40);
        io(16'h0040, 1'b0, 0);
        $display("test decode done");
        wr(XBCS3_IDX_BASE_HIGH, 8'h03);
        wr(XBCS3_IDX_BASE_LOW, 8'h02);
        wr(XBCS3_IDX_BASE_HIGH, 8'h05);
        rd(XBCS3_IDX_BASE_HIGH, 8'h03, "protected high");
        wr(XBCS3_IDX_BASE_LOW, 8'h00);
        rd(XBCS3_IDX_BASE_LOW, 8'h02, "protect stuck");
        io(16'h0300, 1'b1, 36);
        pulse(1'b0);
        rd(XBCS3_IDX_BASE_HIGH, 8'h00, "soft high");
        rd(XBCS3_IDX_BASE_LOW, 8'h02, "soft keeps protect");
        pulse(1'b1);
        rd(XBCS3_IDX_BASE_LOW, 8'h00, "hard clears protect");
        $display("test protect done");
        wr(XBCS3_IDX_SELECT, 8'h80);
        wr(XBCS3_IDX_SELECT, 8'h0c);
        rd(XBCS3_IDX_SELECT, 8'h80, "locked");
        pulse(1'b0);
        rd(XBCS3_IDX_SELECT, 8'h80, "soft keeps lock");
        pulse(1'b1);
        rd(XBCS3_IDX_SELECT, 8'h00, "hard clears lock");
        $display("test lock done");
        print_verdict();
    end
endmodule
